// ==== aeru_pkg.sv ====
// Purpose : constants for the error reporting header and uncorrectable status registers
// Assumes : ahb-lite register access, 32-bit words
// Notes   : offsets are byte addresses
package aeru_pkg;
   localparam logic [11:0] OFS_HEADER       = 12'h100;
   localparam logic [11:0] OFS_UNC_STATUS   = 12'h104;
   localparam logic [11:0] OFS_PORT_CTRL    = 12'h180;
   localparam logic [15:0] CAP_ID_VALUE     = 16'h0001;
   localparam logic [3:0]  CAP_VER_VALUE    = 4'h2;
   localparam logic [11:0] NEXT_PTR_RESET   = 12'h000;
   localparam int          BIT_LEGACY       = 0;
   localparam int          BIT_LINK_PROTO   = 4;
   localparam int          BIT_SURPRISE     = 5;
   localparam int          BIT_POISONED     = 12;
   localparam int          BIT_UNEXP_CPL    = 16;
   localparam int          BIT_RX_OVERFLOW  = 17;
   localparam int          BIT_MALFORMED    = 18;
   localparam int          BIT_ECRC         = 19;
   localparam int          BIT_UNSUPPORTED  = 20;
   localparam int          BIT_ACS_VIOL     = 21;
   localparam int          BIT_INTERNAL     = 22;
   // writable status bits: 0,4,5,12,16..22
   localparam logic [31:0] STATUS_W1C_MASK  = 32'h007f_1031;
   localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
   // port control: bit0 lock, bit1 internal report enable
   localparam int          CTRL_LOCK_BIT    = 0;
   localparam int          CTRL_IE_BIT      = 1;
   localparam logic [1:0]  CTRL_RESET       = 2'h0;
endpackage : aeru_pkg

// ==== aeru_regs.sv ====
// Purpose : error reporting header and sticky uncorrectable error status over ahb-lite
// Assumes : single hclk domain; event inputs are one-cycle pulses from same-clock logic
// Notes   : sticky state survives hot_reset; only hresetn (fundamental) clears it
`timescale 1ns/100ps

// How it works
// - capability identifier reads constant one
// - capability version reads constant two
// - next pointer chains capabilities, zero ends
// - pointer follows mode default, writable when unlocked
// - software written pointer survives mode changes
// - legacy bit sticky w1c, never set
// - link protocol error sets bit four
// - downstream surprise down sets when capable
// - upstream surprise down bit reads zero
// - poisoned packet sets bit twelve
// - flow control error bit reads zero
// - completion timeout bit reads zero
// - completer abort bit reads zero
// - unexpected completion sets bit sixteen
// - receiver overflow sets bit seventeen
// - malformed packet sets bit eighteen
// - ecrc error sets bit nineteen
// - unsupported request sets bit twenty
// - access control violation sets bit 21
// - internal error sets bit 22
// - internal bit reads zero when disabled
module aeru_regs (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hot_reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        port_downstream,
   input  wire logic [11:0] mode_next_ptr,
   input  wire logic        surprise_down_report_capable,
   input  wire logic        ev_link_protocol,
   input  wire logic        ev_surprise_down,
   input  wire logic        ev_poisoned,
   input  wire logic        ev_unexpected_completion,
   input  wire logic        ev_receiver_overflow,
   input  wire logic        ev_malformed,
   input  wire logic        ev_ecrc,
   input  wire logic        ev_unsupported,
   input  wire logic        ev_access_violation,
   input  wire logic        ev_internal,
   output logic      [31:0] status_flags
);

   typedef struct packed {
      logic        wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic [31:0] status;
      logic [11:0] next_ptr;
      logic        ptr_written;
      logic [1:0]  ctrl;
      logic [31:0] flags_out;
   } aeru_state_t;

   aeru_state_t st;
   aeru_state_t next_st;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic [31:0] live_mask;
   logic [31:0] header_word;
   logic [31:0] read_word;
   logic        addr_phase;
   logic        rd_header;
   logic        rd_status;
   logic        wr_header;
   logic        wr_status;

   ////////////////////////////////////////////////////////////////////////
   // event decode and field masking
   always_comb begin
      set_vec = 32'h0000_0000;
      set_vec[aeru_pkg::BIT_LINK_PROTO]  = ev_link_protocol;
      set_vec[aeru_pkg::BIT_SURPRISE]    = ev_surprise_down & port_downstream
                                           & surprise_down_report_capable;
      set_vec[aeru_pkg::BIT_POISONED]    = ev_poisoned;
      set_vec[aeru_pkg::BIT_UNEXP_CPL]   = ev_unexpected_completion;
      set_vec[aeru_pkg::BIT_RX_OVERFLOW] = ev_receiver_overflow;
      set_vec[aeru_pkg::BIT_MALFORMED]   = ev_malformed;
      set_vec[aeru_pkg::BIT_ECRC]        = ev_ecrc;
      set_vec[aeru_pkg::BIT_UNSUPPORTED] = ev_unsupported;
      set_vec[aeru_pkg::BIT_ACS_VIOL]    = ev_access_violation;
      set_vec[aeru_pkg::BIT_INTERNAL]    = ev_internal;
      // bits 13,14,15 absent from mask: read-only zero
      live_mask = aeru_pkg::STATUS_W1C_MASK;
      live_mask[aeru_pkg::BIT_SURPRISE] = port_downstream;
      live_mask[aeru_pkg::BIT_INTERNAL] = st.ctrl[aeru_pkg::CTRL_IE_BIT];
      set_vec = set_vec & live_mask;
   end

   // header word assembly
   assign header_word = {st.next_ptr, aeru_pkg::CAP_VER_VALUE, aeru_pkg::CAP_ID_VALUE};
   assign addr_phase  = hsel & hready & htrans[1];

   // access strobes watched by the checks below
   assign rd_header   = addr_phase & ~hwrite & (haddr[11:0] == aeru_pkg::OFS_HEADER);
   assign rd_status   = addr_phase & ~hwrite & (haddr[11:0] == aeru_pkg::OFS_UNC_STATUS);
   assign wr_header   = st.wr_pend & (st.wr_addr == aeru_pkg::OFS_HEADER);
   assign wr_status   = st.wr_pend & (st.wr_addr == aeru_pkg::OFS_UNC_STATUS);

   // read mux
   always_comb begin
      unique case (haddr[11:0])
         aeru_pkg::OFS_HEADER:     read_word = header_word;
         aeru_pkg::OFS_UNC_STATUS: read_word = st.status & live_mask;
         aeru_pkg::OFS_PORT_CTRL:  read_word = {30'h0000_0000, st.ctrl};
         default:                  read_word = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state
   always_comb begin
      next_st = st;
      clr_vec = 32'h0000_0000;
      next_st.wr_pend = 1'b0;
      if (addr_phase) begin
         next_st.wr_pend = hwrite;
         next_st.wr_addr = haddr[11:0];
         next_st.rdata   = hwrite ? 32'h0000_0000 : read_word;
      end
      if (st.wr_pend) begin
         unique case (st.wr_addr)
            aeru_pkg::OFS_HEADER: begin
               if (!st.ctrl[aeru_pkg::CTRL_LOCK_BIT]) begin
                  next_st.next_ptr    = hwdata[31:20];
                  next_st.ptr_written = 1'b1;
               end
            end
            aeru_pkg::OFS_UNC_STATUS: clr_vec = hwdata;
            aeru_pkg::OFS_PORT_CTRL:  next_st.ctrl = hwdata[1:0];
            default: ;
         endcase
      end
      // hardware default follows mode until software writes it
      if (!next_st.ptr_written) begin
         next_st.next_ptr = mode_next_ptr;
      end
      // set beats clear; legacy bit has no setter
      next_st.status = ((st.status & ~clr_vec) | set_vec) & live_mask;
      next_st.flags_out = next_st.status;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; hot_reset clears only non-sticky bus state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st.wr_pend     <= 1'b0;
         st.wr_addr     <= 12'h000;
         st.rdata       <= 32'h0000_0000;
         st.status      <= aeru_pkg::STATUS_RESET;
         st.next_ptr    <= aeru_pkg::NEXT_PTR_RESET;
         st.ptr_written <= 1'b0;
         st.ctrl        <= aeru_pkg::CTRL_RESET;
         st.flags_out   <= aeru_pkg::STATUS_RESET;
      end else if (hot_reset) begin
         // sticky status, pointer and lock ride through warm reset
         st.wr_pend <= 1'b0;
         st.rdata   <= 32'h0000_0000;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata       = st.rdata;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign status_flags = st.flags_out;

   ////////////////////////////////////////////////////////////////////////
   // checks
   // header and next pointer
   // capability identifier is the constant one
   a_cap_id_const: assert property (@(posedge hclk) disable iff (!hresetn)
      header_word[15:0] == 16'h0001)
      else $error("capability identifier wrong");

   // identifier and version stay constant together
   a_id_version_const: assert property (@(posedge hclk) disable iff (!hresetn)
      header_word[19:0] == 20'h2_0001)
      else $error("header id/version wrong");

   // a header read returns identifier one
   a_id_read_back: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_header |=> hrdata[15:0] == 16'h0001)
      else $error("identifier read wrong");

   // capability version is the constant two
   a_cap_version_const: assert property (@(posedge hclk) disable iff (!hresetn)
      header_word[19:16] == 4'h2)
      else $error("capability version wrong");

   // a header read returns version two
   a_version_field: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_header |=> hrdata[19:16] == 4'h2)
      else $error("version read wrong");

   // a header read returns the held next pointer
   a_ptr_read_back: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_header |=> hrdata[31:20] == $past(st.next_ptr))
      else $error("next pointer read wrong");

   // unwritten pointer tracks the mode default
   a_ptr_follows_mode: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      !st.ptr_written && !next_st.ptr_written |=> st.next_ptr == $past(mode_next_ptr))
      else $error("pointer not following mode");

   // locked header write leaves the pointer written flag alone
   a_lock_blocks_write: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      wr_header && st.ctrl[aeru_pkg::CTRL_LOCK_BIT] |=> st.ptr_written == $past(st.ptr_written))
      else $error("locked pointer written");

   // unlocked header write takes the top twelve bits
   a_unlocked_write: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      wr_header && !st.ctrl[aeru_pkg::CTRL_LOCK_BIT] |=>
      st.ptr_written && {st.next_ptr, 20'h0_0000} == ($past(hwdata) & 32'hfff0_0000))
      else $error("pointer write lost");

   // written pointer ignores mode changes
   a_ptr_held: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      st.ptr_written && !st.wr_pend |=> $stable(st.next_ptr))
      else $error("written pointer lost");

   // once written, the pointer stays software owned
   a_ptr_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      st.ptr_written |=> st.ptr_written)
      else $error("pointer ownership lost");

   // status bits set by events or held at zero
   // legacy bit has no setter
   a_legacy_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      st.status[0] == 1'b0)
      else $error("legacy bit set");

   // link protocol error shows in the flags next cycle
   a_link_err_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_link_protocol |=> status_flags[4])
      else $error("link error not logged");

   // surprise down logged on capable downstream port
   a_surprise_gate: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_surprise_down && port_downstream && surprise_down_report_capable |=> st.status[5])
      else $error("surprise down not logged");

   // no capability, no surprise down logging
   a_surprise_needs_cap: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      !st.status[5] && !(ev_surprise_down && surprise_down_report_capable) |=> !st.status[5])
      else $error("surprise down set without capability");

   // upstream port never holds the surprise bit
   a_upstream_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !$past(port_downstream) |-> !st.status[5])
      else $error("upstream surprise bit set");

   // upstream port reads the surprise bit as zero
   a_upstream_read_zero: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_status && !port_downstream |=> !hrdata[5])
      else $error("upstream surprise bit read");

   // surprise bit clears on a one write
   a_surprise_w1c: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      wr_status && hwdata[5] && !ev_surprise_down |=> !st.status[5])
      else $error("surprise bit not cleared");

   // poisoned packet logged
   a_poison_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_poisoned |=> st.status[12])
      else $error("poisoned not logged");

   // reserved and unsupported bits never set
   a_ro_zero_bits: assert property (@(posedge hclk) disable iff (!hresetn)
      st.status[15:13] == 3'h0 && st.status[3:1] == 3'h0)
      else $error("read-only bits set");

   // flow control bit reads zero
   a_fc_read_zero: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_status |=> !hrdata[13])
      else $error("flow control bit read set");

   // completion timeout bit stays zero
   a_timeout_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.status[14] && !status_flags[14])
      else $error("completion timeout bit set");

   // completer abort bit stays zero
   a_abort_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.status[15] && !status_flags[15])
      else $error("completer abort bit set");

   // unexpected completion logged
   a_unexp_cpl_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_unexpected_completion |=> st.status[16])
      else $error("unexpected completion not logged");

   // receiver overflow logged
   a_overflow_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_receiver_overflow |=> st.status[17])
      else $error("receiver overflow not logged");

   // malformed packet logged
   a_malformed_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_malformed |=> st.status[18])
      else $error("malformed packet not logged");

   // end-to-end crc error logged
   a_ecrc_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_ecrc |=> st.status[19])
      else $error("ecrc error not logged");

   // unsupported request logged
   a_unsupported_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_unsupported |=> st.status[20])
      else $error("unsupported request not logged");

   // access control violation logged
   a_acs_viol_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_access_violation |=> st.status[21])
      else $error("access violation not logged");

   // internal error logged while reporting is enabled
   a_internal_sets: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_internal && st.ctrl[aeru_pkg::CTRL_IE_BIT] |=> st.status[22])
      else $error("internal error not logged");

   // clearing, masking and warm reset
   // disabled reporting forces the internal bit low
   a_internal_disabled: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      !st.ctrl[aeru_pkg::CTRL_IE_BIT] |=> !st.status[22])
      else $error("internal bit set while disabled");

   // disabled reporting reads the internal bit as zero
   a_internal_read_zero: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_status && !st.ctrl[aeru_pkg::CTRL_IE_BIT] |=> !hrdata[22])
      else $error("internal bit read while disabled");

   // status read returns the live bits only
   a_status_read_back: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      rd_status |=> hrdata == ($past(st.status) & $past(live_mask)))
      else $error("status read wrong");

   // an event wins over a simultaneous clear
   a_set_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      ev_receiver_overflow && wr_status |=> st.status[17])
      else $error("set lost to clear");

   // writing one clears the bit
   a_w1c_clears: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      wr_status && hwdata[18] && !ev_malformed |=> !st.status[18])
      else $error("w1c failed");

   // writing zero keeps a set bit
   a_zero_write_keeps: assert property (@(posedge hclk) disable iff (!hresetn || hot_reset)
      wr_status |=> ($past(st.status) & $past(live_mask) & ~$past(hwdata) & ~st.status) == 32'h0000_0000)
      else $error("zero write cleared a bit");

   // warm reset keeps sticky status and control
   a_sticky_hot_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      hot_reset |=> st.status == $past(st.status) && st.ctrl == $past(st.ctrl))
      else $error("warm reset lost sticky state");

endmodule : aeru_regs

// ==== tb_top.sv ====
// Purpose : self-checking bench for the error reporting header and status registers
// Assumes : ahb-lite single word transfers, event lines pulsed one cycle each, except ev[4] held high across one status write
// Notes   : port control at 0x180 holds pointer lock and internal report enable
`timescale 1ns/100ps
module tb_top;
   logic        hclk = 1'b0, hresetn = 1'b0, hot_reset = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, status_flags, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, dn = 1'b1, cap = 1'b1;
   logic [11:0] mptr = 12'h140;
   logic [9:0]  ev = 10'h0;
   int          failures = 0, comparisons = 0;
   int          pos [10] = '{4, 5, 12, 16, 17, 18, 19, 20, 21, 22}; // status bit of each event line
   always #12.5 hclk = ~hclk;
   aeru_regs DUT (.hclk(hclk), .hresetn(hresetn), .hot_reset(hot_reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_downstream(dn),
      .mode_next_ptr(mptr), .surprise_down_report_capable(cap), .ev_link_protocol(ev[0]),
      .ev_surprise_down(ev[1]), .ev_poisoned(ev[2]), .ev_unexpected_completion(ev[3]),
      .ev_receiver_overflow(ev[4]), .ev_malformed(ev[5]), .ev_ecrc(ev[6]), .ev_unsupported(ev[7]),
      .ev_access_violation(ev[8]), .ev_internal(ev[9]), .status_flags(status_flags));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task complete_run;
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // value compare
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait for hready sampled high
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t bus wait timed out", $time);
         complete_run();
      end
   endtask : wait_rdy
   // one ahb-lite single transfer, read data taken at end of data phase
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : xfer
   // read and compare
   task rchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   // one-cycle pulse on an event line, settled after the sampling edge
   task pulse(input int i);
      @(posedge hclk) ev[i] <= 1'b1;
      @(posedge hclk) ev[i] <= 1'b0;
      #1;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(12'h100, 32'h1402_0001);
      @(posedge hclk) mptr <= 12'h000;
      rchk(12'h100, 32'h0002_0001);
      rchk(12'h104, 32'h0);
      rchk(12'h200, 32'h0);
      xfer(1'b1, 12'h180, 32'h1);
      xfer(1'b1, 12'h100, 32'h1230_0000);
      rchk(12'h100, 32'h0002_0001);
      xfer(1'b1, 12'h180, 32'h2);
      xfer(1'b1, 12'h100, 32'h150f_ffff);
      @(posedge hclk) mptr <= 12'h0c0;
      rchk(12'h100, 32'h1502_0001);
      $display("test header done");
      for (int i = 0; i < 10; i++) begin
         pulse(i);
         chk(status_flags, 32'h1 << pos[i]);
         xfer(1'b1, 12'h104, ~(32'h1 << pos[i]));
         rchk(12'h104, 32'h1 << pos[i]);
         xfer(1'b1, 12'h104, 32'h1 << pos[i]);
         rchk(12'h104, 32'h0);
      end
      $display("test events done");
      @(posedge hclk) ev <= 10'h3ff;
      @(posedge hclk) ev <= 10'h0;
      rchk(12'h104, 32'h007f_1030);
      @(posedge hclk) hot_reset <= 1'b1;
      @(posedge hclk) hot_reset <= 1'b0;
      rchk(12'h104, 32'h007f_1030);
      rchk(12'h100, 32'h1502_0001);
      xfer(1'b1, 12'h180, 32'h0);
      rchk(12'h104, 32'h003f_1030);
      @(posedge hclk) dn <= 1'b0;
      rchk(12'h104, 32'h003f_1010);
      xfer(1'b1, 12'h104, 32'hffff_ffff);
      pulse(1);
      pulse(9);
      rchk(12'h104, 32'h0);
      @(posedge hclk) dn <= 1'b1;
      cap <= 1'b0;
      pulse(1);
      rchk(12'h104, 32'h0);
      ev[4] <= 1'b1;
      xfer(1'b1, 12'h104, 32'h0002_0000);
      ev[4] <= 1'b0;
      rchk(12'h104, 32'h0002_0000);
      $display("test masking done");
      pulse(0);
      @(posedge hclk) hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(12'h104, 32'h0);
      rchk(12'h100, 32'h0c02_0001);
      $display("test reset done");
      complete_run();
   end
endmodule : tb_top
